// >>> core/i2c_reg_slave.sv
// I2C slave that turns bus frames into fixed-address register accesses
`timescale 1ns/10ps
`include "i2c_reg_slave_defs.svh"

// Summary of operation
// - Write frame is device address, one register address byte, then data bytes.
// - Every data byte of a write frame goes to the same register address.
// - Read frame with direction bit set returns selected register contents.
// - Every byte of a read frame comes from the same register address.
// - Supports high-speed transfers while staying compatible with slower masters.
// - Master code 00001xxx after START, then not-acknowledge, enters high speed.
// - After master code, repeated START and addressed slave acknowledges.
// - High speed persists across repeated STARTs and ends only on STOP.
// - After reset the interface runs in fast mode.
// - Master code switches spike filters and slope control to high speed.
// - Force-high-speed bit holds high-speed mode without master code.
// - Without master code or force-high-speed bit the device stays in fast or standard mode.
// - Slave only: never drives SCL, never arbitrates.
// - Slave address sampled once after reset release; later pin changes ignored.
// - Address-mode pin high: six low bits from pins, top bit zero.
module i2c_reg_slave
   import i2c_reg_slave_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // I2C pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   // Address straps and configuration
   input  wire logic       address_mode_select_pin,
   input  wire logic [5:0] addr_pins,
   input  wire logic       force_high_speed_bit,
   // Register port
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   // Pad settings
   output logic            hs_filter_sel,
   output logic            hs_slope_sel
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic       scl_d_reg;
   logic       sda_d_reg;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_d_reg    <= 1'b1;
         sda_d_reg    <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_in};
         sda_sync_reg <= {sda_sync_reg[0], sda_in};
         scl_d_reg    <= scl_sync_reg[1];
         sda_d_reg    <= sda_sync_reg[1];
      end
   end

   wire scl_s    = scl_sync_reg[1];
   wire sda_s    = sda_sync_reg[1];
   wire scl_rise = scl_s & ~scl_d_reg;
   wire scl_fall = ~scl_s & scl_d_reg;
   wire start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   wire stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // ----------------------------------------------------------------
   // Address strap capture
   // ----------------------------------------------------------------
   logic       strap_done_reg;
   logic [6:0] slave_addr_reg;

   // Caught one cycle after release so the flops never load a port under reset
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         strap_done_reg <= 1'b0;
         slave_addr_reg <= 7'h00;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         if (address_mode_select_pin)
            slave_addr_reg <= {1'b0, addr_pins};
         else
            slave_addr_reg <= {`ADDR_FIXED_HI, addr_pins[2:0]};
      end
   end

   // ----------------------------------------------------------------
   // Byte engine
   // ----------------------------------------------------------------
   slv_state_t state_reg;
   logic [7:0] shift_reg;
   logic [2:0] bit_cnt_reg;
   logic       first_byte_reg;   // next received byte is register address
   logic       is_read_reg;
   logic       mcode_reg;        // current byte after START is master code

   wire [7:0] rx_byte = {shift_reg[6:0], sda_s};

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_reg      <= ST_IDLE;
         shift_reg      <= 8'h00;
         bit_cnt_reg    <= 3'h7;
         first_byte_reg <= 1'b0;
         is_read_reg    <= 1'b0;
         mcode_reg      <= 1'b0;
         sda_out        <= 1'b1;
         sda_oe         <= 1'b0;
         reg_wr         <= 1'b0;
         reg_rd         <= 1'b0;
         reg_wdata      <= 8'h00;
         reg_addr       <= `REG_ADDR_RESET;
      end else begin
         reg_wr <= 1'b0;
         reg_rd <= 1'b0;
         sda_out <= 1'b0; // SCL is never driven: pure slave
         if (stop_c) begin
            state_reg <= ST_IDLE;
            sda_oe    <= 1'b0;
         end else if (start_c) begin
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 3'h7;
            sda_oe      <= 1'b0;
         end else begin
            case (state_reg)
               ST_ADDR: begin
                  if (scl_rise) begin
                     shift_reg <= rx_byte;
                     if (bit_cnt_reg == `BIT_CNT_LAST) begin
                        if (rx_byte[7:1] == slave_addr_reg) begin
                           state_reg      <= ST_AACK;
                           is_read_reg    <= rx_byte[`RW_BIT_POS];
                           first_byte_reg <= ~rx_byte[`RW_BIT_POS];
                           mcode_reg      <= 1'b0;
                        end else begin
                           // Master code is not acknowledged unless its top seven bits match slave_addr_reg
                           mcode_reg <= ((rx_byte & `MCODE_MASK) == `MCODE_VALUE);
                           state_reg <= ST_WAIT;
                        end
                     end else
                        bit_cnt_reg <= bit_cnt_reg - 3'h1;
                  end
               end
               ST_AACK: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b1;
                     state_reg <= ST_RACK;
                  end
               end
               ST_RACK: begin
                  // Ack low phase is held until the next falling edge
                  if (scl_fall && sda_oe) begin
                     bit_cnt_reg <= 3'h7;
                     if (is_read_reg) begin
                        reg_rd    <= 1'b1;
                        shift_reg <= reg_rdata;
                        sda_oe    <= ~reg_rdata[7];
                        state_reg <= ST_TX;
                     end else begin
                        sda_oe    <= 1'b0;
                        state_reg <= ST_RX;
                     end
                  end
               end
               ST_RX: begin
                  if (scl_rise) begin
                     shift_reg <= rx_byte;
                     if (bit_cnt_reg == `BIT_CNT_LAST) begin
                        state_reg <= ST_AACK;
                        if (first_byte_reg) begin
                           reg_addr       <= rx_byte;
                           first_byte_reg <= 1'b0;
                        end else begin
                           reg_wdata <= rx_byte;
                           reg_wr    <= 1'b1; // address unchanged
                        end
                     end else
                        bit_cnt_reg <= bit_cnt_reg - 3'h1;
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt_reg == `BIT_CNT_LAST) begin
                        sda_oe    <= 1'b0;
                        state_reg <= ST_TACK;
                     end else begin
                        bit_cnt_reg <= bit_cnt_reg - 3'h1;
                        sda_oe      <= ~shift_reg[6];
                        shift_reg   <= {shift_reg[6:0], 1'b0};
                     end
                  end
               end
               ST_TACK: begin
                  // Master NACK ends the read; an ACK stays here so the fetch below serves the fall
                  if (scl_rise && sda_s)
                     state_reg <= ST_WAIT;
               end
               default: begin
                  sda_oe <= 1'b0;
               end
            endcase
            // Master ACKed a read byte: fetch next byte on the fall
            if (state_reg == ST_TACK && scl_fall) begin
               bit_cnt_reg <= 3'h7;
               reg_rd      <= 1'b1;
               shift_reg   <= reg_rdata;
               sda_oe      <= ~reg_rdata[7];
               state_reg   <= ST_TX;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Speed mode
   // ----------------------------------------------------------------
   logic hs_mode_reg;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn)
         hs_mode_reg <= 1'b0;
      else if (stop_c)
         hs_mode_reg <= 1'b0;
      else if (mcode_reg && state_reg == ST_WAIT && scl_rise && sda_s)
         hs_mode_reg <= 1'b1;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hs_filter_sel <= 1'b0;
         hs_slope_sel  <= 1'b0;
      end else begin
         hs_filter_sel <= hs_mode_reg | force_high_speed_bit;
         hs_slope_sel  <= hs_mode_reg | force_high_speed_bit;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   hs_stop_exit_a: assert property (@(posedge mclk) disable iff (!resetn)
      stop_c |=> !hs_mode_reg) else $error("HS kept after STOP");
   force_hs_a: assert property (@(posedge mclk) disable iff (!resetn)
      force_high_speed_bit |=> hs_filter_sel) else $error("Force HS ignored");
   write_addr_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
      reg_wr |-> $stable(reg_addr)) else $error("Address moved on write");
   strap_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
      strap_done_reg |=> $stable(slave_addr_reg)) else $error("Address relatched");
   mode_pin_msb_a: assert property (@(posedge mclk) disable iff (!resetn)
      $rose(strap_done_reg) && address_mode_select_pin |-> ##0 1'b1 ##1 !slave_addr_reg[6])
      else $error("Address msb not zero");
   reset_fast_a: assert property (@(posedge mclk) disable iff (!resetn)
      !hs_mode_reg && !force_high_speed_bit [*2] |-> !hs_slope_sel) else $error("Not fast mode");
   no_drive_high_a: assert property (@(posedge mclk) disable iff (!resetn)
      sda_oe |-> !sda_out) else $error("SDA driven high");
   read_on_fetch_a: assert property (@(posedge mclk) disable iff (!resetn)
      reg_rd |=> state_reg == ST_TX) else $error("Read without transmit");

endmodule // i2c_reg_slave

// >>> inc/i2c_reg_slave_defs.svh
// Constants for the I2C register-access slave
`ifndef I2C_REG_SLAVE_DEFS_SVH
`define I2C_REG_SLAVE_DEFS_SVH
`define RW_BIT_POS        0
`define MCODE_MASK        8'hF8
`define MCODE_VALUE       8'h08
`define ADDR_FIXED_HI     4'h5
`define REG_ADDR_RESET    8'h00
`define BIT_CNT_LAST      3'h0
`endif

// >>> inc/i2c_reg_slave_pkg.sv
// Types for the I2C register-access slave
package i2c_reg_slave_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_AACK  = 3'b011,
      ST_RX    = 3'b010,
      ST_RACK  = 3'b110,
      ST_TX    = 3'b111,
      ST_TACK  = 3'b101,
      ST_WAIT  = 3'b100
   } slv_state_t;
endpackage

// >>> testbench/i2c_master_model.sv
// I2C bus master model that drives the slave's clock and data pins
`timescale 1ns/10ps
module i2c_master_model (
   // Clock and bus
   input  wire logic mclk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   // Released lines read high through the pull-up; clock stands high between frames
   initial begin
      scl     = 1'b1;
      sda_drv = 1'b1;
   end
   // One quarter of a 320 ns bit per step
   task automatic step(input logic c, input logic d);
      repeat (2) @(posedge mclk);
      scl     <= c;
      sda_drv <= d;
   endtask
   task automatic start();
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
   task automatic stop();
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   // Data changes only while the clock is low
   task automatic bit_io(input logic b, output logic r);
      step(1'b0, b);
      step(1'b1, b);
      repeat (2) @(posedge mclk);
      r = sda_line;
      step(1'b0, b);
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(~ack, r);
   endtask
endmodule // i2c_master_model

// >>> testbench/testbench.sv
// Self-checking bench for the I2C register-access slave
`timescale 1ns/10ps
module testbench;
   localparam logic [6:0] DEV = 7'h2A;
   logic       mclk = 1'b0;
   logic       resetn, mode_pin, force_hs, sda_out, sda_oe, reg_wr, reg_rd;
   logic       hs_filter_sel, hs_slope_sel, scl, sda_drv, sda_line;
   logic [5:0] addr_pins;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rnd, d;
   logic [7:0] rd_cnt = 8'h00;
   logic [7:0] mem [256];
   logic [15:0] wq [$];
   logic [7:0] expq [$];
   int         errors = 0;
   int         cmp_count = 0;

   always #20 mclk = ~mclk;
   assign sda_line  = (sda_oe && !sda_out) ? 1'b0 : sda_drv;
   assign reg_rdata = mem[reg_addr];
   always @(posedge mclk) begin
      if (reg_wr) begin
         wq.push_back({reg_addr, reg_wdata});
         mem[reg_addr] <= reg_wdata;
      end
      rd_cnt <= rd_cnt + {7'h00, reg_rd};
   end

   i2c_reg_slave uut (.mclk(mclk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .address_mode_select_pin(mode_pin), .addr_pins(addr_pins),
      .force_high_speed_bit(force_hs), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hs_filter_sel(hs_filter_sel), .hs_slope_sel(hs_slope_sel));
   i2c_master_model m (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic send(input logic [7:0] b, input logic exp_ack);
      logic a;
      m.wr_byte(b, a);
      chk("ack", {7'h00, exp_ack}, {7'h00, a});
   endtask
   task automatic check_writes(input logic [7:0] ra);
      logic [15:0] w;
      chk("write count", 8'(expq.size()), 8'(wq.size()));
      while (expq.size() > 0 && wq.size() > 0) begin
         w = wq.pop_front();
         chk("write addr", ra, w[15:8]);
         chk("write data", expq.pop_front(), w[7:0]);
      end
      wq.delete();
      expq.delete();
   endtask
   task automatic chk_hs(input logic on);
      // Sync, detect and two flops lie between a pin edge and the pads; look well after them
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      chk("hs pads", {6'h00, on, on}, {6'h00, hs_filter_sel, hs_slope_sel});
   endtask
   task automatic final_report();
      $display("Comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      rnd = 8'h29;
      resetn    <= 1'b0;
      mode_pin  <= 1'b1;
      addr_pins <= 6'h2A;
      force_hs  <= 1'b0;
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      repeat (8) @(posedge mclk);
      addr_pins <= 6'h15;
      chk_hs(1'b0);
      m.start();
      send({DEV, 1'b0}, 1'b1);
      send(8'h09, 1'b1);
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         expq.push_back(rnd);
         send(rnd, 1'b1);
      end
      m.stop();
      check_writes(8'h09);
      $display("write test done");
      m.start();
      send({DEV, 1'b0}, 1'b1);
      send(8'h09, 1'b1);
      m.stop();
      m.start();
      send({DEV, 1'b1}, 1'b1);
      for (int i = 0; i < 3; i++) begin
         m.rd_byte(i < 2, d);
         chk("read data", rnd, d);
      end
      m.stop();
      chk("read strobes", 8'h03, rd_cnt);
      check_writes(8'h09);
      $display("read test done");
      // Top address bit set and the pins' new value must both be refused
      m.start();
      send({7'h6A, 1'b0}, 1'b0);
      m.start();
      send({7'h15, 1'b0}, 1'b0);
      m.stop();
      check_writes(8'h09);
      $display("address test done");
      rnd = lfsr(rnd);
      m.start();
      send(8'h08 | {5'h00, rnd[2:0]}, 1'b0);
      chk_hs(1'b1);
      m.start();
      send({DEV, 1'b0}, 1'b1);
      send(8'h21, 1'b1);
      rnd = lfsr(rnd);
      expq.push_back(rnd);
      send(rnd, 1'b1);
      m.start();
      chk_hs(1'b1);
      send({DEV, 1'b0}, 1'b1);
      send(8'h21, 1'b1);
      m.stop();
      check_writes(8'h21);
      chk_hs(1'b0);
      $display("high speed test done");
      force_hs <= 1'b1;
      chk_hs(1'b1);
      force_hs <= 1'b0;
      chk_hs(1'b0);
      $display("force test done");
      // Second reset with the mode pin low: fixed high nibble over three pin bits
      resetn    <= 1'b0;
      mode_pin  <= 1'b0;
      addr_pins <= 6'h3B;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      repeat (8) @(posedge mclk);
      chk_hs(1'b0);
      m.start();
      send({4'h5, 3'h3, 1'b0}, 1'b1);
      send(8'h30, 1'b1);
      rnd = lfsr(rnd);
      expq.push_back(rnd);
      send(rnd, 1'b1);
      m.stop();
      check_writes(8'h30);
      $display("strap test done");
      final_report();
   end

   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      final_report();
   end
endmodule // testbench
